/* File: hdl/vip_pkg.sv */
/*
 * Constants shared by the vectored interrupt prioritizer: vector table layout,
 * source numbering, register offsets and reset values.
 * Assumes a 24-bit program address space and 32-bit register data.
 */
package vip_pkg;
	// ------------------------------------------------------------------
	// Vector table
	// ------------------------------------------------------------------
	localparam logic [23:0] VEC_RESET = 24'h00_0004;
	localparam logic [23:0] VEC_SYSEXC = 24'h00_0008;
	localparam logic [23:0] VEC_RESERVED = 24'h00_000C;
	localparam logic [23:0] VEC_BASE = 24'h00_0010;
	localparam int VEC_ENTRY_BYTES = 4;
	localparam int HANDLER_MSB = 23;

	// ------------------------------------------------------------------
	// Source numbering, slot 0 is vector VEC_BASE
	// ------------------------------------------------------------------
	localparam int NUM_SRC = 24;
	localparam int SRC_IDX_W = 5;
	localparam int LEVEL_W = 2;
	localparam int NUM_PERIPH = 12;
	localparam int PERIPH_LOW = 8;
	localparam int PERIPH_HIGH_BASE = 16;
	localparam int AD_TOP_SLOT = 15;
	localparam int PC_TOP_SLOT = 23;
	localparam int NUM_AD_PINS = 8;
	localparam int NUM_PC_PINS = 4;
	localparam int AD_CMP_PIN = 7;
	localparam int AD_DBG_PIN = 0;

	// ------------------------------------------------------------------
	// Register map, byte offsets
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFF_EDGE_SEL = 8'h00;
	localparam logic [7:0] OFF_PORT_SEL = 8'h04;
	localparam logic [7:0] OFF_ROUTE_SEL = 8'h08;
	localparam logic [7:0] OFF_PC_SEL = 8'h0C;
	localparam logic [7:0] OFF_LEVEL_LO = 8'h14;
	localparam logic [7:0] OFF_LEVEL_HI = 8'h18;
	localparam logic [7:0] OFF_PENDING = 8'h1C;
	localparam logic [7:0] OFF_SW_SET = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam int ROUTE_CMP_BIT = 7;
	localparam int ROUTE_DBG_BIT = 0;
	localparam int STAT_GE_BIT = 0;
	localparam int STAT_REQ_BIT = 1;
	localparam int STAT_EXC_BIT = 2;
	localparam int STAT_IDX_LSB = 8;
	localparam int FLAG_GE_BIT = 0;
	localparam logic [7:0] RST_SEL8 = 8'h00;
	localparam logic [3:0] RST_SEL4 = 4'h0;
	localparam logic [31:0] RST_LEVEL_LO = 32'h0000_0000;
	localparam logic [15:0] RST_LEVEL_HI = 16'h0000;
endpackage

/* File: hdl/pin_edge_detect.sv */
/*
 * Edge detector for a group of synchronous pin levels, one pulse per edge
 * that the per-bit rise and fall enables select.
 * Assumes inputs are already synchronous to clk.
 */
`timescale 1ns/1ns
module pin_edge_detect #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Levels and edge choice
	input wire logic [WIDTH-1:0] level,
	input wire logic [WIDTH-1:0] rise_en,
	input wire logic [WIDTH-1:0] fall_en,
	// One-cycle edge pulses
	output logic [WIDTH-1:0] pulse
);
	logic [WIDTH-1:0] prev_ff;
	logic primed_ff;

	// No edge on the first sample, a pin held high at reset is not a rise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			primed_ff <= 1'b0;
		end else begin
			primed_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= level;
		end
	end

	always_comb begin
		pulse = '0;
		if (primed_ff) begin
			pulse = (level & ~prev_ff & rise_en) | (~level & prev_ff & fall_en);
		end
	end
endmodule // pin_edge_detect

/* File: hdl/vectored_interrupt_prioritizer.sv */
/*
 * Vectored interrupt prioritizer: source routing, edge detection, pending
 * flags, three-level arbitration, global enable and vector handoff to the CPU.
 * Assumes a CPU that pulses its instruction and acknowledge events for one
 * cycle and fetches the vector word from the address presented.
 */
`timescale 1ns/1ns
module vectored_interrupt_prioritizer
	import vip_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Interrupt sources
	input wire logic [NUM_PERIPH-1:0] periph_irq,
	input wire logic [NUM_AD_PINS-1:0] port_a,
	input wire logic [NUM_AD_PINS-1:0] port_d,
	input wire logic [NUM_PC_PINS-1:0] port_c,
	input wire logic comparator_out,
	input wire logic on_chip_debug_source,
	input wire logic [NUM_PC_PINS-1:0] dma_irq,
	input wire logic sysexc_req,
	// CPU events
	input wire logic enable_irq_instruction,
	input wire logic disable_irq_instruction,
	input wire logic trap_instruction,
	input wire logic sysexc_taken,
	input wire logic return_from_irq_instruction,
	input wire logic [7:0] popped_flags,
	input wire logic flag_load,
	input wire logic [7:0] flag_load_value,
	input wire logic irq_ack,
	// Vector fetch
	input wire logic vec_word_valid,
	input wire logic [31:0] vec_word,
	// To CPU
	output logic irq_req,
	output logic [23:0] irq_vec_addr,
	output logic [23:0] reset_vec_addr,
	output logic [23:0] handler_addr,
	output logic global_irq_enable
);
	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	logic [7:0] pin_edge_select_ff;
	logic [7:0] port_a_or_d_select_ff;
	logic comparator_route_select_ff;
	logic debug_route_select_ff;
	logic [3:0] port_c_or_dma_select_ff;
	logic [31:0] level_lo_ff;
	logic [15:0] level_hi_ff;
	logic [NUM_SRC-1:0] pend_ff;
	logic [NUM_SRC-1:0] nxt_pend;
	logic ge_ff;
	logic req_ff;
	logic exc_ff;
	logic [SRC_IDX_W-1:0] idx_ff;
	logic [23:0] vec_ff;
	logic [23:0] handler_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [LEVEL_W*NUM_SRC-1:0] level_all;
	logic [NUM_AD_PINS-1:0] ad_level;
	logic [NUM_AD_PINS-1:0] ad_pulse;
	logic [NUM_PC_PINS-1:0] pc_pulse;
	logic cmp_pulse;
	logic [NUM_SRC-1:0] ev;
	logic [NUM_SRC-1:0] sw_set;
	logic [NUM_SRC-1:0] sw_clr;
	logic [NUM_SRC-1:0] ack_clr;
	logic [SRC_IDX_W:0] winner;
	logic win_found;
	logic [SRC_IDX_W-1:0] win_idx;
	logic [23:0] win_addr;

	function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off,
			input logic wr);
		return wr && (a == off);
	endfunction

	function automatic logic [23:0] slot_addr(input logic [SRC_IDX_W-1:0] idx);
		return VEC_BASE + {17'h0_0000, idx, 2'b00};
	endfunction

	// Strict compare keeps the lowest slot on a tie; level zero never wins
	function automatic logic [SRC_IDX_W:0] pick_winner(input logic [NUM_SRC-1:0] pend,
			input logic [LEVEL_W*NUM_SRC-1:0] lv);
		logic [SRC_IDX_W:0] res;
		logic [LEVEL_W-1:0] best;
		res = '0;
		best = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (pend[i] && (lv[LEVEL_W*i +: LEVEL_W] > best)) begin
				best = lv[LEVEL_W*i +: LEVEL_W];
				res = {1'b1, SRC_IDX_W'(i)};
			end
		end
		return res;
	endfunction

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_edge_select_ff <= RST_SEL8;
			port_a_or_d_select_ff <= RST_SEL8;
			comparator_route_select_ff <= 1'b0;
			debug_route_select_ff <= 1'b0;
			port_c_or_dma_select_ff <= RST_SEL4;
		end else begin
			if (wr_hit(reg_addr, OFF_EDGE_SEL, reg_wr)) begin
				pin_edge_select_ff <= reg_wdata[7:0];
			end
			if (wr_hit(reg_addr, OFF_PORT_SEL, reg_wr)) begin
				port_a_or_d_select_ff <= reg_wdata[7:0];
			end
			if (wr_hit(reg_addr, OFF_ROUTE_SEL, reg_wr)) begin
				comparator_route_select_ff <= reg_wdata[ROUTE_CMP_BIT];
				debug_route_select_ff <= reg_wdata[ROUTE_DBG_BIT];
			end
			if (wr_hit(reg_addr, OFF_PC_SEL, reg_wr)) begin
				port_c_or_dma_select_ff <= reg_wdata[3:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_lo_ff <= RST_LEVEL_LO;
			level_hi_ff <= RST_LEVEL_HI;
		end else begin
			if (wr_hit(reg_addr, OFF_LEVEL_LO, reg_wr)) begin
				level_lo_ff <= reg_wdata;
			end
			if (wr_hit(reg_addr, OFF_LEVEL_HI, reg_wr)) begin
				level_hi_ff <= reg_wdata[15:0];
			end
		end
	end

	assign level_all = {level_hi_ff, level_lo_ff};

	// ------------------------------------------------------------------
	// Source routing and edge detection
	// ------------------------------------------------------------------
	// Pin choice is muxed before the detector, so flipping the port select
	// can itself look like an edge; software should mask the slot first
	assign ad_level = (port_a & ~port_a_or_d_select_ff) | (port_d & port_a_or_d_select_ff);

	pin_edge_detect #(
		.WIDTH(NUM_AD_PINS)
	) u_ad_edges (
		.clk(clk),
		.rst_n(rst_n),
		.level(ad_level),
		.rise_en(pin_edge_select_ff),
		.fall_en(~pin_edge_select_ff),
		.pulse(ad_pulse)
	);

	pin_edge_detect #(
		.WIDTH(NUM_PC_PINS)
	) u_pc_edges (
		.clk(clk),
		.rst_n(rst_n),
		.level(port_c),
		.rise_en({NUM_PC_PINS{1'b1}}),
		.fall_en({NUM_PC_PINS{1'b1}}),
		.pulse(pc_pulse)
	);

	pin_edge_detect #(
		.WIDTH(1)
	) u_cmp_edges (
		.clk(clk),
		.rst_n(rst_n),
		.level(comparator_out),
		.rise_en(1'b1),
		.fall_en(1'b1),
		.pulse(cmp_pulse)
	);

	assign ev[PERIPH_LOW-1:0] = periph_irq[PERIPH_LOW-1:0];
	assign ev[PERIPH_HIGH_BASE+NUM_PERIPH-PERIPH_LOW-1:PERIPH_HIGH_BASE] =
		periph_irq[NUM_PERIPH-1:PERIPH_LOW];

	generate
		for (genvar p = 0; p < NUM_AD_PINS; p++) begin : g_ad
			if (p == AD_CMP_PIN) begin : g_cmp
				assign ev[AD_TOP_SLOT-p] = comparator_route_select_ff ? cmp_pulse : ad_pulse[p];
			end else if (p == AD_DBG_PIN) begin : g_dbg
				assign ev[AD_TOP_SLOT-p] = debug_route_select_ff ? on_chip_debug_source :
					ad_pulse[p];
			end else begin : g_pin
				assign ev[AD_TOP_SLOT-p] = ad_pulse[p];
			end
		end
		for (genvar p = 0; p < NUM_PC_PINS; p++) begin : g_pc
			assign ev[PC_TOP_SLOT-p] = port_c_or_dma_select_ff[p] ? pc_pulse[p] : dma_irq[p];
		end
	endgenerate

	// ------------------------------------------------------------------
	// Pending flags
	// ------------------------------------------------------------------
	always_comb begin
		sw_set = '0;
		sw_clr = '0;
		ack_clr = '0;
		if (wr_hit(reg_addr, OFF_SW_SET, reg_wr)) begin
			sw_set = reg_wdata[NUM_SRC-1:0];
		end
		if (wr_hit(reg_addr, OFF_PENDING, reg_wr)) begin
			sw_clr = reg_wdata[NUM_SRC-1:0];
		end
		if (irq_ack && req_ff && !exc_ff) begin
			ack_clr[idx_ff] = 1'b1;
		end
		// A new event in the clearing cycle survives
		nxt_pend = (pend_ff & ~(sw_clr | ack_clr)) | ev | sw_set;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_ff <= '0;
		end else begin
			pend_ff <= nxt_pend;
		end
	end

	// ------------------------------------------------------------------
	// Global enable
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ge_ff <= 1'b0;
		end else if (disable_irq_instruction || trap_instruction || sysexc_taken) begin
			ge_ff <= 1'b0;
		end else if (irq_ack) begin
			ge_ff <= 1'b0;
		end else if (return_from_irq_instruction) begin
			ge_ff <= popped_flags[FLAG_GE_BIT];
		end else if (flag_load) begin
			ge_ff <= flag_load_value[FLAG_GE_BIT];
		end else if (enable_irq_instruction) begin
			ge_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Arbitration and vector output
	// ------------------------------------------------------------------
	assign winner = pick_winner(pend_ff, level_all);
	assign win_found = winner[SRC_IDX_W];
	assign win_idx = winner[SRC_IDX_W-1:0];
	assign win_addr = slot_addr(win_idx);

	// Slot 000Ch has no source and is never presented
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_ff <= 1'b0;
			exc_ff <= 1'b0;
			idx_ff <= '0;
			vec_ff <= VEC_SYSEXC;
		end else if (sysexc_req) begin
			req_ff <= 1'b1;
			exc_ff <= 1'b1;
			vec_ff <= VEC_SYSEXC;
		end else if (ge_ff && win_found && !irq_ack) begin
			req_ff <= 1'b1;
			exc_ff <= 1'b0;
			idx_ff <= win_idx;
			vec_ff <= win_addr;
		end else begin
			req_ff <= 1'b0;
			exc_ff <= 1'b0;
		end
	end

	// Vector word byte 3 is ignored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			handler_ff <= '0;
		end else if (vec_word_valid) begin
			handler_ff <= vec_word[HANDLER_MSB:0];
		end
	end

	// ------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				OFF_EDGE_SEL: rdata_ff <= {24'h00_0000, pin_edge_select_ff};
				OFF_PORT_SEL: rdata_ff <= {24'h00_0000, port_a_or_d_select_ff};
				OFF_ROUTE_SEL: rdata_ff <= {24'h00_0000, comparator_route_select_ff, 6'h00,
					debug_route_select_ff};
				OFF_PC_SEL: rdata_ff <= {28'h000_0000, port_c_or_dma_select_ff};
				OFF_LEVEL_LO: rdata_ff <= level_lo_ff;
				OFF_LEVEL_HI: rdata_ff <= {16'h0000, level_hi_ff};
				OFF_PENDING: rdata_ff <= {8'h00, pend_ff};
				OFF_STATUS: rdata_ff <= {19'h0_0000, idx_ff, 5'h00, exc_ff, req_ff, ge_ff};
				default: rdata_ff <= '0;
			endcase
		end else begin
			rdata_ff <= '0;
		end
	end

	assign reg_rdata = rdata_ff;
	assign irq_req = req_ff;
	assign irq_vec_addr = vec_ff;
	assign reset_vec_addr = VEC_RESET;
	assign handler_addr = handler_ff;
	assign global_irq_enable = ge_ff;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence ack_s;
		irq_ack && !sysexc_req;
	endsequence

	sequence quiet_cpu_s;
		!disable_irq_instruction && !trap_instruction && !sysexc_taken && !irq_ack;
	endsequence

	ack_disables_a: assert property (@(posedge clk) disable iff (!rst_n)
		ack_s |=> (!global_irq_enable && !irq_req))
		else $error("acknowledge did not drop enable and request");

	trap_disables_a: assert property (@(posedge clk) disable iff (!rst_n)
		(trap_instruction || disable_irq_instruction || sysexc_taken) |=> !global_irq_enable)
		else $error("enable survived a disabling event");

	insn_enables_a: assert property (@(posedge clk) disable iff (!rst_n)
		(enable_irq_instruction && !return_from_irq_instruction && !flag_load) ##0 quiet_cpu_s
		|=> global_irq_enable)
		else $error("enable instruction did not set enable");

	flag_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		(flag_load && !return_from_irq_instruction) ##0 quiet_cpu_s
		|=> global_irq_enable == $past(flag_load_value[FLAG_GE_BIT]))
		else $error("flag load did not set enable from bit 0");

	return_restores_a: assert property (@(posedge clk) disable iff (!rst_n)
		return_from_irq_instruction ##0 quiet_cpu_s
		|=> global_irq_enable == $past(popped_flags[FLAG_GE_BIT]))
		else $error("return did not restore enable from popped flags");

	exc_nonmask_a: assert property (@(posedge clk) disable iff (!rst_n)
		sysexc_req |=> (irq_req && irq_vec_addr == VEC_SYSEXC))
		else $error("exception not presented at its vector");

	masked_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!global_irq_enable && !sysexc_req) |=> !irq_req)
		else $error("request shown while globally disabled");

	winner_shown_a: assert property (@(posedge clk) disable iff (!rst_n)
		(global_irq_enable && win_found && !sysexc_req && !irq_ack)
		|=> (irq_req && irq_vec_addr == $past(win_addr)))
		else $error("best pending request not presented");

	no_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
		irq_req |-> (irq_vec_addr != VEC_RESERVED && irq_vec_addr != VEC_RESET))
		else $error("reserved or reset slot presented");

	level_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		win_found |-> (level_all[LEVEL_W*win_idx +: LEVEL_W] != 2'h0))
		else $error("masked source won arbitration");

	pin_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
		($past(rst_n, 2) && !port_a_or_d_select_ff[1] && $stable(port_a_or_d_select_ff[1])
		&& !pin_edge_select_ff[1] && $fell(port_a[1])) |=> pend_ff[AD_TOP_SLOT-1])
		else $error("falling edge on pin one not latched");

	dma_route_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!port_c_or_dma_select_ff[0] && dma_irq[0]) |=> pend_ff[PC_TOP_SLOT])
		else $error("DMA request not latched on its slot");
endmodule // vectored_interrupt_prioritizer

/* File: test/cpu_partner.sv */
/*
 * CPU partner model: acknowledges level requests and returns vector words.
 * Assumes the prioritizer's clk domain and a request that holds until acked.
 */
`timescale 1ns/1ns
module cpu_partner (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request from prioritizer
	input wire logic irq_req,
	input wire logic [23:0] irq_vec_addr,
	// Acknowledge and vector fetch
	output logic irq_ack,
	output logic vec_word_valid,
	output logic [31:0] vec_word
);
	logic [23:0] addr_l;
	int dly;
	initial begin
		irq_ack = 1'b0;
		vec_word_valid = 1'b0;
		vec_word = 32'h0000_0000;
		forever begin
			@(posedge clk);
			if (rst_n === 1'b1 && irq_req === 1'b1) begin
				// Random delay gives prompt and slow acknowledges
				dly = $urandom_range(3, 0);
				repeat (dly) @(posedge clk);
				irq_ack <= 1'b1;
				addr_l = irq_vec_addr;
				@(posedge clk);
				irq_ack <= 1'b0;
				@(posedge clk);
				vec_word_valid <= 1'b1;
				vec_word <= {8'($urandom), 8'h5A, addr_l[15:0]};
				@(posedge clk);
				vec_word_valid <= 1'b0;
				// Stale word inverted so nobody can lean on it
				vec_word <= ~vec_word;
				while (irq_req === 1'b1) @(posedge clk);
			end
		end
	end
endmodule // cpu_partner

/* File: test/tb.sv */
/*
 * Self-checking bench for the vectored interrupt prioritizer.
 * Assumes cpu_partner answers requests; bench drives all other inputs.
 */
`timescale 1ns/1ns
module tb import vip_pkg::*;;
	typedef struct packed {logic [31:0] val; logic [31:0] mask;} exp_s;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr, port_a, port_d, flag_val, na, nd, esel, psel, route;
	logic [31:0] reg_wdata, reg_rdata, vec_word;
	logic reg_wr, reg_rd, comparator_out, dbg, sysexc_req, irq_ack, vec_word_valid;
	logic irq_req, global_irq_enable, ncmp, ndbg, o, n, hit;
	logic rd_seen = 1'b0;
	logic hv_seen = 1'b0;
	logic [11:0] periph_irq, nper;
	logic [3:0] port_c, dma_irq, nc, ndma, csel;
	logic [5:0] ev;
	logic [23:0] irq_vec_addr, reset_vec_addr, handler_addr, cur_vec, pend_m;
	logic [47:0] lvl_m;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	int r, s;
	exp_s e;
	exp_s rd_q[$];
	logic [23:0] vec_q[$];
	logic [7:0] offs[10] = '{OFF_EDGE_SEL, OFF_PORT_SEL, OFF_ROUTE_SEL, OFF_PC_SEL,
		OFF_LEVEL_LO, OFF_LEVEL_HI, OFF_PENDING, OFF_SW_SET, OFF_STATUS, 8'h40};
	int evb[10] = '{0, 4, 4, 1, 0, 2, 0, 3, 5, 5};
	logic vb[10] = '{0, 0, 1, 1, 0, 1, 0, 1, 1, 0};

	always #5 clk = ~clk;

	vectored_interrupt_prioritizer dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.periph_irq(periph_irq), .port_a(port_a), .port_d(port_d), .port_c(port_c),
		.comparator_out(comparator_out), .on_chip_debug_source(dbg), .dma_irq(dma_irq),
		.sysexc_req(sysexc_req), .enable_irq_instruction(ev[0]),
		.disable_irq_instruction(ev[1]), .trap_instruction(ev[2]), .sysexc_taken(ev[3]),
		.return_from_irq_instruction(ev[5]), .popped_flags(flag_val), .flag_load(ev[4]),
		.flag_load_value(flag_val), .irq_ack(irq_ack), .vec_word_valid(vec_word_valid),
		.vec_word(vec_word), .irq_req(irq_req), .irq_vec_addr(irq_vec_addr),
		.reset_vec_addr(reset_vec_addr), .handler_addr(handler_addr),
		.global_irq_enable(global_irq_enable));

	cpu_partner partner_u (.clk(clk), .rst_n(rst_n), .irq_req(irq_req),
		.irq_vec_addr(irq_vec_addr), .irq_ack(irq_ack), .vec_word_valid(vec_word_valid),
		.vec_word(vec_word));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("counts: checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
		rd_q.push_back('{x & m, m});
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic pulse(input int b, input logic [7:0] v);
		@(posedge clk);
		ev[b] <= 1'b1;
		flag_val <= v;
		@(posedge clk);
		ev <= '0;
	endtask
	task automatic wait_ack();
		for (int i = 0; i < 40 && irq_ack !== 1'b1; i++) @(posedge clk);
		check("irq_ack", irq_ack, 1);
	endtask
	function automatic int best_slot(input logic [23:0] p, input logic [47:0] l);
		for (int v = 3; v >= 1; v--)
			for (int k = 0; k < 24; k++)
				if (p[k] && l[2*k +: 2] == v) return k;
		return -1;
	endfunction

	// ------------------------------------------------------------------
	// Monitor and timeout
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			print_verdict();
		end
	end

	always @(posedge clk) begin
		if (rd_seen) begin
			e = rd_q.pop_front();
			check("reg_rdata", reg_rdata & e.mask, e.val);
		end
		rd_seen <= reg_rd;
		if (irq_ack === 1'b1) begin
			cur_vec = vec_q.pop_front();
			check("irq_vec_addr", irq_vec_addr, cur_vec);
		end
		if (hv_seen) check("handler_addr", handler_addr, {8'h5A, cur_vec[15:0]});
		hv_seen <= vec_word_valid;
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, periph_irq, port_a, port_d} = '0;
		{port_c, comparator_out, dbg, dma_irq, sysexc_req, ev, flag_val} = '0;
		r = $urandom(25);
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check("reset_vec_addr", reset_vec_addr, 32'h0000_0004);
		for (int i = 0; i < 10; i++)
			rd(offs[i], 0, offs[i] == OFF_STATUS ? 32'h0000_0007 : 32'hFFFF_FFFF);
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			pulse(evb[i], {7'($urandom), vb[i]});
			rd(OFF_STATUS, (i % 2 == 0), 32'h0000_0001);
		end
		$display("test enable done");
		for (int pass = 0; pass < 2; pass++) begin
			// First pass keeps pin one falling on port A and slot 006Ch on DMA
			esel = 8'($urandom) & (pass ? 8'hFF : 8'hFD);
			psel = 8'($urandom) & (pass ? 8'hFF : 8'hFD);
			csel = 4'($urandom) & (pass ? 4'hF : 4'hE);
			route = pass ? 8'h81 : 8'h00;
			wr(OFF_EDGE_SEL, {24'h00_0000, esel});
			wr(OFF_PORT_SEL, {24'h00_0000, psel});
			wr(OFF_ROUTE_SEL, {24'($urandom), route | (8'($urandom) & 8'h7E)});
			wr(OFF_PC_SEL, {28'h000_0000, csel});
			rd(OFF_ROUTE_SEL, {24'h00_0000, route}, 32'hFFFF_FFFF);
			// Select changes may pend spurious edges, so clear after settling
			repeat (3) @(posedge clk);
			wr(OFF_PENDING, 32'h00FF_FFFF);
			pend_m = '0;
			repeat (3) @(posedge clk);
			for (int k = 0; k < 12; k++) begin
				@(posedge clk);
				na = port_a ^ (8'($urandom) & 8'($urandom));
				nd = port_d ^ (8'($urandom) & 8'($urandom) & 8'($urandom));
				nc = port_c ^ (4'($urandom) & 4'($urandom));
				nper = 12'($urandom) & 12'($urandom) & 12'($urandom);
				ndma = 4'($urandom) & 4'($urandom);
				ncmp = comparator_out ^ ($urandom_range(3, 0) == 0);
				ndbg = ($urandom_range(3, 0) == 0);
				for (int p = 0; p < 8; p++) begin
					o = psel[p] ? port_d[p] : port_a[p];
					n = psel[p] ? nd[p] : na[p];
					hit = esel[p] ? (!o && n) : (o && !n);
					if (p == 7 && route[7]) hit = comparator_out ^ ncmp;
					if (p == 0 && route[0]) hit = ndbg;
					if (hit) pend_m[15-p] = 1'b1;
				end
				for (int p = 0; p < 4; p++)
					if (csel[p] ? port_c[p] ^ nc[p] : ndma[p]) pend_m[23-p] = 1'b1;
				pend_m[7:0] = pend_m[7:0] | nper[7:0];
				pend_m[19:16] = pend_m[19:16] | nper[11:8];
				{port_a, port_d, port_c, periph_irq} <= {na, nd, nc, nper};
				{dma_irq, comparator_out, dbg} <= {ndma, ncmp, ndbg};
			end
			@(posedge clk);
			{periph_irq, dma_irq, dbg} <= '0;
			repeat (4) @(posedge clk);
			rd(OFF_PENDING, {8'h00, pend_m}, 32'hFFFF_FFFF);
			check("irq_req", irq_req, 0);
		end
		$display("test pins done");
		wr(OFF_PENDING, 32'h00FF_FFFF);
		lvl_m = {16'($urandom), 32'($urandom)};
		wr(OFF_LEVEL_LO, lvl_m[31:0]);
		wr(OFF_LEVEL_HI, {16'h0000, lvl_m[47:32]});
		rd(OFF_LEVEL_HI, {16'h0000, lvl_m[47:32]}, 32'hFFFF_FFFF);
		pend_m = 24'($urandom);
		wr(OFF_SW_SET, {8'h00, pend_m});
		repeat (3) @(posedge clk);
		check("irq_req", irq_req, 0);
		for (int k = 0; k < 25; k++) begin
			s = best_slot(pend_m, lvl_m);
			if (s < 0) break;
			vec_q.push_back(24'h00_0010 + 24'(4 * s));
			pulse(0, 8'h00);
			wait_ack();
			pend_m[s] = 1'b0;
			repeat (4) @(posedge clk);
			check("global_irq_enable", global_irq_enable, 0);
		end
		pulse(0, 8'h00);
		repeat (4) @(posedge clk);
		check("irq_req", irq_req, 0);
		rd(OFF_PENDING, {8'h00, pend_m}, 32'hFFFF_FFFF);
		pulse(1, 8'h01);
		$display("test priority done");
		vec_q.push_back(24'h00_0008);
		@(posedge clk);
		sysexc_req <= 1'b1;
		wait_ack();
		sysexc_req <= 1'b0;
		pulse(3, 8'h01);
		rd(OFF_STATUS, 0, 32'h0000_0001);
		$display("test exception done");
		pulse(0, 8'h00);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		check("global_irq_enable", global_irq_enable, 0);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd(OFF_STATUS, 0, 32'h0000_0001);
		rd(OFF_PENDING, 0, 32'hFFFF_FFFF);
		$display("test midreset done");
		repeat (4) @(posedge clk);
		print_verdict();
	end
endmodule // tb
